/* File: rtl/fcs_map.svh */
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH

// software register byte offsets
`define FCS_REG_CTRL 5'h00
`define FCS_REG_ADDR 5'h04
`define FCS_REG_WDATA 5'h08
`define FCS_REG_STATUS 5'h0C
`define FCS_REG_RDATA 5'h10

// operation codes written to the control register
`define FCS_OP_READ 3'h0
`define FCS_OP_ID_ENTER 3'h1
`define FCS_OP_RESET 3'h2
`define FCS_OP_PROGRAM 3'h3
`define FCS_OP_ERASE 3'h4
`define FCS_OP_PROT 3'h5

// status register bit positions
`define FCS_ST_BUSY 0
`define FCS_ST_ID_MODE 1
`define FCS_ST_ERR 2
`define FCS_ST_VFAIL 3
`define FCS_ST_DONE 4

// flash command bus values
`define FCS_UNLOCK_ADDR1 17'h05555
`define FCS_UNLOCK_ADDR2 17'h02AAA
`define FCS_UNLOCK_DATA1 8'hAA
`define FCS_UNLOCK_DATA2 8'h55
`define FCS_CMD_ID 8'h90
`define FCS_CMD_RESET 8'hF0
`define FCS_CMD_PROGRAM 8'hA0
`define FCS_CMD_ERASE_SETUP 8'h80
`define FCS_CMD_CHIP_ERASE 8'h10
`define FCS_PROT_LOW 14'h0002
`define FCS_TOGGLE_BIT 6
`define FCS_ERROR_BIT 5

// pin timing
`define FCS_CLK_NS 25
`define FCS_T_WP_NS 50
`define FCS_T_ACC_NS 90
`define FCS_WP_CYC ((`FCS_T_WP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ACC_CYC ((`FCS_T_ACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

/* File: rtl/fcs_pkg.sv */
package fcs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEQ,
    ST_POLL_A,
    ST_POLL_B,
    ST_VERIFY,
    ST_RECOVER
  } fcs_state_t;

  typedef enum logic [2:0] {
    CY_IDLE,
    CY_SETUP,
    CY_PULSE,
    CY_HOLD,
    CY_READ,
    CY_GAP
  } fcs_cyc_t;

  typedef struct packed {
    logic rd;
    logic last;
    logic [16:0] addr;
    logic [7:0] data;
  } fcs_step_t;

endpackage : fcs_pkg

/* File: rtl/fcs_pin_cycle.sv */
`timescale 1ns/1ps
`include "fcs_map.svh"
// one flash bus cycle: write with select before strobe, or timed read
module fcs_pin_cycle #(
  parameter int WP_CYC = `FCS_WP_CYC,
  parameter int ACC_CYC = `FCS_ACC_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic req_rd,
  input wire logic [16:0] req_addr,
  input wire logic [7:0] req_data,
  output logic done,
  output logic [7:0] rd_byte,
  output logic [16:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in
);
  localparam logic [3:0] WP_LAST = 4'(WP_CYC - 1);
  localparam logic [3:0] RD_LAST = 4'(ACC_CYC + 1);

  fcs_pkg::fcs_cyc_t cyc_ff, nxt_cyc;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] dq_meta_ff, dq_sync_ff;
  logic done_ff, nxt_done;
  logic [7:0] rd_byte_ff, nxt_rd_byte;
  logic [16:0] addr_ff, nxt_addr;
  logic ce_n_ff, nxt_ce_n, we_n_ff, nxt_we_n, oe_n_ff, nxt_oe_n;
  logic [7:0] dq_out_ff, nxt_dq_out;
  logic dq_oe_ff, nxt_dq_oe;

  always_comb begin
    nxt_cyc = cyc_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_rd_byte = rd_byte_ff;
    nxt_addr = addr_ff;
    nxt_ce_n = ce_n_ff;
    nxt_we_n = 1'b1;
    nxt_oe_n = oe_n_ff;
    nxt_dq_out = dq_out_ff;
    nxt_dq_oe = dq_oe_ff;
    case (cyc_ff)
      fcs_pkg::CY_IDLE: begin
        if (req) begin
          // address settles with select, before the strobe falls
          nxt_addr = req_addr;
          nxt_ce_n = 1'b0;
          nxt_cnt = 4'h0;
          if (req_rd) begin
            nxt_oe_n = 1'b0;
            nxt_dq_oe = 1'b0;
            nxt_cyc = fcs_pkg::CY_READ;
          end else begin
            // output enable stays high for the whole write
            nxt_oe_n = 1'b1;
            nxt_dq_out = req_data;
            nxt_dq_oe = 1'b1;
            nxt_cyc = fcs_pkg::CY_SETUP;
          end
        end
      end
      fcs_pkg::CY_SETUP: begin
        nxt_we_n = 1'b0;
        nxt_cyc = fcs_pkg::CY_PULSE;
      end
      fcs_pkg::CY_PULSE: begin
        if (cnt_ff == WP_LAST) begin
          nxt_cyc = fcs_pkg::CY_HOLD;
        end else begin
          nxt_we_n = 1'b0;
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      fcs_pkg::CY_HOLD: begin
        // strobe rose first and data is still driven: that edge latches it
        nxt_ce_n = 1'b1;
        nxt_cyc = fcs_pkg::CY_GAP;
      end
      fcs_pkg::CY_READ: begin
        // two extra cycles cover the input synchroniser
        if (cnt_ff == RD_LAST) begin
          nxt_rd_byte = dq_sync_ff;
          nxt_ce_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_cyc = fcs_pkg::CY_GAP;
        end else begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      fcs_pkg::CY_GAP: begin
        nxt_dq_oe = 1'b0;
        nxt_done = 1'b1;
        nxt_cyc = fcs_pkg::CY_IDLE;
      end
      default: nxt_cyc = fcs_pkg::CY_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cyc_ff <= fcs_pkg::CY_IDLE;
      cnt_ff <= 4'h0;
      dq_meta_ff <= 8'h00;
      dq_sync_ff <= 8'h00;
      done_ff <= 1'b0;
      rd_byte_ff <= 8'h00;
      addr_ff <= 17'h00000;
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      dq_out_ff <= 8'h00;
      dq_oe_ff <= 1'b0;
    end else begin
      cyc_ff <= nxt_cyc;
      cnt_ff <= nxt_cnt;
      dq_meta_ff <= flash_dq_in;
      dq_sync_ff <= dq_meta_ff;
      done_ff <= nxt_done;
      rd_byte_ff <= nxt_rd_byte;
      addr_ff <= nxt_addr;
      ce_n_ff <= nxt_ce_n;
      we_n_ff <= nxt_we_n;
      oe_n_ff <= nxt_oe_n;
      dq_out_ff <= nxt_dq_out;
      dq_oe_ff <= nxt_dq_oe;
    end
  end

  assign done = done_ff;
  assign rd_byte = rd_byte_ff;
  assign flash_addr = addr_ff;
  assign flash_ce_n = ce_n_ff;
  assign flash_we_n = we_n_ff;
  assign flash_oe_n = oe_n_ff;
  assign flash_dq_out = dq_out_ff;
  assign flash_dq_oe = dq_oe_ff;

  property p_write_gate;
    @(posedge clock) disable iff (sys_rst)
      !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe;
  endproperty
  a_write_gate: assert property (p_write_gate)
    else $error("write strobe low without select or with output on");

  property p_no_read_in_write;
    @(posedge clock) disable iff (sys_rst)
      !flash_oe_n |-> flash_we_n && !flash_dq_oe;
  endproperty
  a_no_read_in_write: assert property (p_no_read_in_write)
    else $error("read and write cycle overlap");

  property p_we_width;
    @(posedge clock) disable iff (sys_rst)
      $fell(flash_we_n) |-> (!flash_we_n)[*2] ##1 flash_we_n;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe width wrong");

  property p_data_at_rise;
    @(posedge clock) disable iff (sys_rst)
      $rose(flash_we_n) |-> $stable(flash_dq_out) && flash_dq_oe
        && !flash_ce_n;
  endproperty
  a_data_at_rise: assert property (p_data_at_rise)
    else $error("data not held at strobe rise");

  property p_addr_stable;
    @(posedge clock) disable iff (sys_rst)
      !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved while selected");

endmodule : fcs_pin_cycle

/* File: rtl/fcs_controller.sv */
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "fcs_map.svh"
// host-side controller driving a byte-wide command-sequenced flash
module fcs_controller (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [16:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in
);
  localparam int SEQ_LAST_ERASE = 5;

  fcs_pkg::fcs_state_t state_ff, nxt_state;
  logic [2:0] op_ff, nxt_op;
  logic [2:0] idx_ff, nxt_idx;
  logic pend_ff, nxt_pend;
  logic [16:0] addr_reg_ff, nxt_addr_reg;
  logic [7:0] wdata_reg_ff, nxt_wdata_reg;
  logic [7:0] rdata_reg_ff, nxt_rdata_reg;
  logic id_mode_ff, nxt_id_mode;
  logic err_ff, nxt_err;
  logic vfail_ff, nxt_vfail;
  logic done_ff, nxt_done;
  logic tog_ff, nxt_tog;
  logic recheck_ff, nxt_recheck;
  logic [31:0] rdata_ff, nxt_rdata;

  logic cyc_req;
  logic cyc_done;
  logic [7:0] cyc_byte;
  fcs_pkg::fcs_step_t step;
  fcs_pkg::fcs_step_t cur;

  function automatic fcs_pkg::fcs_step_t wr_step(input logic [16:0] a,
      input logic [7:0] d, input logic last);
    fcs_pkg::fcs_step_t s;
    s.rd = 1'b0;
    s.last = last;
    s.addr = a;
    s.data = d;
    return s;
  endfunction : wr_step

  function automatic fcs_pkg::fcs_step_t rd_step(input logic [16:0] a);
    fcs_pkg::fcs_step_t s;
    s.rd = 1'b1;
    s.last = 1'b1;
    s.addr = a;
    s.data = 8'h00;
    return s;
  endfunction : rd_step

  // bus cycle at position idx of operation op; unlock cycles put zero in
  // bits 16:15, which the device ignores there
  function automatic fcs_pkg::fcs_step_t seq_step(input logic [2:0] op,
      input logic [2:0] idx, input logic [16:0] a, input logic [7:0] d);
    fcs_pkg::fcs_step_t s;
    logic [7:0] cmd;
    s = rd_step(a);
    case (op)
      `FCS_OP_ID_ENTER: cmd = `FCS_CMD_ID;
      `FCS_OP_RESET: cmd = `FCS_CMD_RESET;
      `FCS_OP_PROGRAM: cmd = `FCS_CMD_PROGRAM;
      default: cmd = `FCS_CMD_ERASE_SETUP;
    endcase
    if (op == `FCS_OP_READ) begin
      s = rd_step(a);
    end else if (op == `FCS_OP_PROT) begin
      s = rd_step({a[16:14], `FCS_PROT_LOW});
    end else begin
      case (idx)
        3'h0: s = wr_step(`FCS_UNLOCK_ADDR1, `FCS_UNLOCK_DATA1, 1'b0);
        3'h1: s = wr_step(`FCS_UNLOCK_ADDR2, `FCS_UNLOCK_DATA2, 1'b0);
        3'h2: s = wr_step(`FCS_UNLOCK_ADDR1, cmd, op == `FCS_OP_RESET);
        3'h3: begin
          if (op == `FCS_OP_ID_ENTER) begin
            s = rd_step(a);
          end else if (op == `FCS_OP_PROGRAM) begin
            s = wr_step(a, d, 1'b1);
          end else begin
            s = wr_step(`FCS_UNLOCK_ADDR1, `FCS_UNLOCK_DATA1, 1'b0);
          end
        end
        3'h4: s = wr_step(`FCS_UNLOCK_ADDR2, `FCS_UNLOCK_DATA2, 1'b0);
        default: begin
          s = wr_step(`FCS_UNLOCK_ADDR1, `FCS_CMD_CHIP_ERASE, 1'b1);
        end
      endcase
    end
    return s;
  endfunction : seq_step

  function automatic logic op_valid(input logic [2:0] op);
    return op <= `FCS_OP_PROT;
  endfunction : op_valid

  always_comb begin
    step = seq_step(op_ff, idx_ff, addr_reg_ff, wdata_reg_ff);
    if (state_ff == fcs_pkg::ST_RECOVER) begin
      cur = seq_step(`FCS_OP_RESET, idx_ff, addr_reg_ff, wdata_reg_ff);
    end else if (state_ff == fcs_pkg::ST_SEQ) begin
      cur = step;
    end else begin
      // polling and verify read the target; any address toggles
      cur = rd_step(addr_reg_ff);
    end
  end

  assign cyc_req = (state_ff != fcs_pkg::ST_IDLE) && !pend_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_idx = idx_ff;
    nxt_pend = pend_ff;
    nxt_addr_reg = addr_reg_ff;
    nxt_wdata_reg = wdata_reg_ff;
    nxt_rdata_reg = rdata_reg_ff;
    nxt_id_mode = id_mode_ff;
    nxt_err = err_ff;
    nxt_vfail = vfail_ff;
    nxt_done = done_ff;
    nxt_tog = tog_ff;
    nxt_recheck = recheck_ff;
    nxt_rdata = 32'h00000000;

    if (reg_wr && state_ff == fcs_pkg::ST_IDLE) begin
      // registers are frozen while an operation runs, so nothing mid
      // sequence can be altered or a command slipped
      case (reg_addr)
        `FCS_REG_ADDR: nxt_addr_reg = reg_wdata[16:0];
        `FCS_REG_WDATA: nxt_wdata_reg = reg_wdata[7:0];
        `FCS_REG_CTRL: begin
          if (op_valid(reg_wdata[2:0])) begin
            nxt_op = reg_wdata[2:0];
            nxt_idx = 3'h0;
            nxt_pend = 1'b0;
            nxt_done = 1'b0;
            nxt_vfail = 1'b0;
            nxt_recheck = 1'b0;
            nxt_state = fcs_pkg::ST_SEQ;
          end
        end
        default: nxt_rdata = 32'h00000000;
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        `FCS_REG_CTRL: nxt_rdata = {29'h0, op_ff};
        `FCS_REG_ADDR: nxt_rdata = {15'h0, addr_reg_ff};
        `FCS_REG_WDATA: nxt_rdata = {24'h0, wdata_reg_ff};
        `FCS_REG_STATUS: nxt_rdata = {27'h0, done_ff, vfail_ff, err_ff,
                                      id_mode_ff,
                                      state_ff != fcs_pkg::ST_IDLE};
        `FCS_REG_RDATA: nxt_rdata = {24'h0, rdata_reg_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
    end

    if (cyc_req) begin
      nxt_pend = 1'b1;
    end else if (cyc_done) begin
      nxt_pend = 1'b0;
      case (state_ff)
        fcs_pkg::ST_SEQ: begin
          if (!step.last) begin
            nxt_idx = idx_ff + 3'h1;
          end else begin
            nxt_idx = 3'h0;
            if (step.rd) begin
              // codes by low address byte, repeatable in id mode
              nxt_rdata_reg = cyc_byte;
            end
            case (op_ff)
              `FCS_OP_ID_ENTER: nxt_id_mode = 1'b1;
              `FCS_OP_RESET: begin
                nxt_id_mode = 1'b0;
                nxt_err = 1'b0;
              end
              default: nxt_id_mode = id_mode_ff;
            endcase
            if (op_ff == `FCS_OP_PROGRAM || op_ff == `FCS_OP_ERASE) begin
              // erase runs alone inside; host only polls
              nxt_state = fcs_pkg::ST_POLL_A;
            end else begin
              nxt_done = 1'b1;
              nxt_state = fcs_pkg::ST_IDLE;
            end
          end
        end
        fcs_pkg::ST_POLL_A: begin
          nxt_tog = cyc_byte[`FCS_TOGGLE_BIT];
          nxt_state = fcs_pkg::ST_POLL_B;
        end
        fcs_pkg::ST_POLL_B: begin
          nxt_rdata_reg = cyc_byte;
          if (cyc_byte[`FCS_TOGGLE_BIT] == tog_ff) begin
            // toggling stopped: back in array read
            if (op_ff == `FCS_OP_PROGRAM) begin
              nxt_state = fcs_pkg::ST_VERIFY;
            end else begin
              nxt_done = 1'b1;
              nxt_state = fcs_pkg::ST_IDLE;
            end
          end else if (cyc_byte[`FCS_ERROR_BIT] && recheck_ff) begin
            // still toggling after the error flag rose
            nxt_err = 1'b1;
            nxt_idx = 3'h0;
            nxt_state = fcs_pkg::ST_RECOVER;
          end else begin
            nxt_recheck = cyc_byte[`FCS_ERROR_BIT];
            nxt_state = fcs_pkg::ST_POLL_A;
          end
        end
        fcs_pkg::ST_VERIFY: begin
          // a one cannot be written over a zero; such a byte reads back different and sets vfail
          nxt_rdata_reg = cyc_byte;
          nxt_vfail = cyc_byte != wdata_reg_ff;
          nxt_done = 1'b1;
          nxt_state = fcs_pkg::ST_IDLE;
        end
        fcs_pkg::ST_RECOVER: begin
          if (idx_ff == 3'h2) begin
            nxt_idx = 3'h0;
            nxt_id_mode = 1'b0;
            nxt_done = 1'b1;
            nxt_state = fcs_pkg::ST_IDLE;
          end else begin
            nxt_idx = idx_ff + 3'h1;
          end
        end
        default: nxt_state = fcs_pkg::ST_IDLE;
      endcase
    end
  end

  // reset leaves no sequence in flight in the controller; nothing resets the flash's own state
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= fcs_pkg::ST_IDLE;
      op_ff <= 3'h0;
      idx_ff <= 3'h0;
      pend_ff <= 1'b0;
      addr_reg_ff <= 17'h00000;
      wdata_reg_ff <= 8'hFF;
      rdata_reg_ff <= 8'h00;
      id_mode_ff <= 1'b0;
      err_ff <= 1'b0;
      vfail_ff <= 1'b0;
      done_ff <= 1'b0;
      tog_ff <= 1'b0;
      recheck_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      idx_ff <= nxt_idx;
      pend_ff <= nxt_pend;
      addr_reg_ff <= nxt_addr_reg;
      wdata_reg_ff <= nxt_wdata_reg;
      rdata_reg_ff <= nxt_rdata_reg;
      id_mode_ff <= nxt_id_mode;
      err_ff <= nxt_err;
      vfail_ff <= nxt_vfail;
      done_ff <= nxt_done;
      tog_ff <= nxt_tog;
      recheck_ff <= nxt_recheck;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  fcs_pin_cycle u_cycle (
    .clock(clock),
    .sys_rst(sys_rst),
    .req(cyc_req),
    .req_rd(cur.rd),
    .req_addr(cur.addr),
    .req_data(cur.data),
    .done(cyc_done),
    .rd_byte(cyc_byte),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in)
  );

  property p_unlock_first;
    @(posedge clock) disable iff (sys_rst)
      cyc_req && state_ff == fcs_pkg::ST_SEQ && idx_ff == 3'h0 && !cur.rd
        |-> cur.addr == `FCS_UNLOCK_ADDR1 && cur.data == `FCS_UNLOCK_DATA1;
  endproperty
  a_unlock_first: assert property (p_unlock_first)
    else $error("command sequence without first unlock");

  property p_erase_final;
    @(posedge clock) disable iff (sys_rst)
      cyc_req && state_ff == fcs_pkg::ST_SEQ && op_ff == `FCS_OP_ERASE
        && idx_ff == 3'(SEQ_LAST_ERASE)
        |-> !cur.rd && cur.data == `FCS_CMD_CHIP_ERASE && cur.last;
  endproperty
  a_erase_final: assert property (p_erase_final)
    else $error("chip erase final cycle wrong");

  property p_program_data;
    @(posedge clock) disable iff (sys_rst)
      cyc_req && state_ff == fcs_pkg::ST_SEQ && op_ff == `FCS_OP_PROGRAM
        && idx_ff == 3'h3
        |-> !cur.rd && cur.addr == addr_reg_ff && cur.data == wdata_reg_ff;
  endproperty
  a_program_data: assert property (p_program_data)
    else $error("program data cycle wrong");

  property p_err_recover;
    @(posedge clock) disable iff (sys_rst)
      $rose(err_ff) |-> state_ff == fcs_pkg::ST_RECOVER;
  endproperty
  a_err_recover: assert property (p_err_recover)
    else $error("error flag without reset recovery");

  property p_id_exit;
    @(posedge clock) disable iff (sys_rst)
      cyc_done && state_ff == fcs_pkg::ST_SEQ && op_ff == `FCS_OP_RESET
        && idx_ff == 3'h2 |=> !id_mode_ff && state_ff == fcs_pkg::ST_IDLE;
  endproperty
  a_id_exit: assert property (p_id_exit)
    else $error("reset did not leave identification mode");

  property p_id_enter;
    @(posedge clock) disable iff (sys_rst)
      cyc_done && state_ff == fcs_pkg::ST_SEQ && op_ff == `FCS_OP_ID_ENTER
        && idx_ff == 3'h3 |=> id_mode_ff && done_ff;
  endproperty
  a_id_enter: assert property (p_id_enter)
    else $error("query did not enter identification mode");

endmodule : fcs_controller

/* File: verification/fcs_flash_model.sv */
`timescale 1ns/1ps
// behavioural byte-wide flash; no clock, decoded on pin edges
module fcs_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] PROT = 8'h05
) (
  input wire logic [16:0] addr,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [7:0] dq_wr,
  input wire logic dq_wr_oe,
  input wire logic err_inj,
  input wire logic [31:0] busy_reads,
  output logic [7:0] dq_rd
);
  logic [7:0] mem [0:131071];
  logic [16:0] la;
  logic [7:0] program_value, lq, rv, idv;
  logic wact, ract, idm, tog, st;
  int s, busy;
  initial begin // power-up in array read, nothing held
    foreach (mem[i]) mem[i] = 8'hFF;
    s = 0;
    busy = 0;
    {idm, tog, wact, ract, st, program_value, lq} = '0;
  end
  task automatic cmd(input logic [16:0] a, input logic [7:0] d);
    logic u1, u2;
    u1 = a[14:0] == 15'h5555; // bits 16:15 ignored
    u2 = a[14:0] == 15'h2AAA;
    if (busy > 0 && !err_inj) return;
    case (s) // any wrong write drops the sequence
      0, 4: s = (u1 && d == 8'hAA) ? s + 1 : 0;
      1, 5: s = (u2 && d == 8'h55) ? s + 1 : 0;
      2: begin
        s = (u1 && d == 8'hA0) ? 3 : (u1 && d == 8'h80) ? 4 : 0;
        if (u1 && d == 8'h90) idm = 1;
        if (u1 && d == 8'hF0) begin
          idm = 0;
          busy = 0;
        end
      end
      3: begin // clears bits only, any order
        s = 0;
        program_value = d;
        mem[a] = mem[a] & d;
        busy = busy_reads + 1;
      end
      6: begin
        s = 0;
        if (u1 && d == 8'h10) begin
          foreach (mem[i]) mem[i] = 8'h00;
          foreach (mem[i]) mem[i] = 8'hFF;
          program_value = 8'hFF;
          busy = busy_reads + 1;
        end
      end
      default: s = 0;
    endcase
  endtask : cmd
  // address at the later fall, only with output off
  always @(negedge ce_n or negedge we_n)
    if (!ce_n && !we_n && oe_n) begin
      la = addr;
      wact = 1;
    end
  // data at the earlier rise; undriven bus gives junk
  always @(posedge ce_n or posedge we_n)
    if (wact) begin
      wact = 0;
      cmd(la, dq_wr_oe ? dq_wr : ~lq);
    end
  // level-sensitive so simultaneous select and enable count once
  always @(ce_n or oe_n)
    if (!ce_n && !oe_n && !ract) begin
      ract = 1;
      st = busy > 0; // status until done
      if (st) begin
        tog = ~tog;
        if (!err_inj) busy = busy - 1;
      end
    end else if (ce_n || oe_n) begin
      ract = 0;
      lq = rv;
    end
  assign idv = addr[7:0] == 8'h00 ? MAKER_CODE :
    addr[7:0] == 8'h01 ? DEV_CODE :
    addr[7:0] == 8'h02 ? {7'h00, PROT[addr[16:14]]} : 8'h00;
  assign rv = st ? {~program_value[7], tog, err_inj, 5'h00} :
    idm ? idv : mem[addr];
  assign dq_rd = (!ce_n && !oe_n) ? rv : ~lq;
endmodule : fcs_flash_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`include "fcs_map.svh"
module tb_top;
  localparam logic [7:0] MAKER = 8'hC3; // arbitrary value
  localparam logic [7:0] DEV = 8'hA5; // arbitrary value
  localparam logic [7:0] PROT = 8'h96;
  logic clock, sys_rst, reg_wr, reg_rd, ce_n, we_n, oe_n, dq_oe, err_inj;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [16:0] fa, a;
  logic [7:0] dq_out, dq_in, d, e;
  logic [7:0] em [bit [16:0]];
  int failures, num_checks, busy_reads;
  fcs_controller uut (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(fa),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
  fcs_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEV), .PROT(PROT)) flash (
    .addr(fa), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq_wr(dq_out),
    .dq_wr_oe(dq_oe), .err_inj(err_inj), .busy_reads(busy_reads),
    .dq_rd(dq_in));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    num_checks++;
    if (got !== ex) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, ex);
    end
  endtask : chk
  task automatic wr(input logic [4:0] ad, input logic [31:0] dt);
    @(posedge clock);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] ad, output logic [31:0] dt);
    @(posedge clock);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 dt = reg_rdata;
  endtask : rd
  task automatic op(input logic [2:0] c, input logic [16:0] ad,
    input logic [7:0] dt);
    int n;
    wr(`FCS_REG_ADDR, {15'h0, ad});
    wr(`FCS_REG_WDATA, {24'h0, dt});
    wr(`FCS_REG_CTRL, {29'h0, c});
    // must be dropped while busy, else target and readback go wrong
    wr(`FCS_REG_ADDR, {15'h0, ~ad});
    n = 0;
    v = 32'h1;
    while (v[`FCS_ST_BUSY] !== 1'b0) begin
      rd(`FCS_REG_STATUS, v);
      n++;
      if (n > 3000) begin
        failures++;
        results();
      end
    end
  endtask : op
  task automatic rchk(input logic [2:0] c, input logic [16:0] ad,
    input logic [7:0] ex);
    op(c, ad, 8'hFF);
    rd(`FCS_REG_RDATA, v);
    chk(v, {24'h0, ex});
  endtask : rchk
  function automatic logic [7:0] cur(input logic [16:0] ad);
    return em.exists(ad) ? em[ad] : 8'hFF;
  endfunction : cur
  // programming can only clear bits, so expectation is an and
  function automatic logic [7:0] pexp(input logic [16:0] ad,
    input logic [7:0] dt);
    em[ad] = cur(ad) & dt;
    return em[ad];
  endfunction : pexp
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, err_inj} = '0;
    sys_rst = 1'b1;
    busy_reads = 0;
    void'($urandom(32'h968F054E));
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`FCS_REG_STATUS, v);
    chk(v, 32'h0);
    rd(5'h14, v);
    chk(v, 32'h0);
    for (int i = 0; i < 12; i++) begin // repeats hit 0 to 1 attempts
      if (i % 3 != 2) a = 17'($urandom);
      d = 8'($urandom);
      busy_reads = int'($urandom % 6);
      op(`FCS_OP_PROGRAM, a, d);
      e = pexp(a, d);
      chk(v, {27'h0, 1'b1, e !== d, 3'h0});
      rchk(`FCS_OP_READ, a, e);
    end
    op(`FCS_OP_ID_ENTER, 17'h0, 8'hFF);
    chk(32'(v[`FCS_ST_ID_MODE]), 32'h1);
    rd(`FCS_REG_RDATA, v);
    chk(v, {24'h0, MAKER});
    for (int i = 0; i < 8; i++) begin
      a = {i[2:0], 6'($urandom), 8'h00};
      rchk(`FCS_OP_READ, a, MAKER);
      rchk(`FCS_OP_READ, a | 17'h1, DEV);
      rchk(`FCS_OP_READ, a | 17'h2, {7'h0, PROT[i]});
      rchk(`FCS_OP_PROT, a | 17'h155, {7'h0, PROT[i]});
    end
    op(`FCS_OP_RESET, 17'h0, 8'hFF);
    chk(32'(v[`FCS_ST_ID_MODE]), 32'h0);
    a = 17'h1FF01;
    rchk(`FCS_OP_READ, a, cur(a));
    err_inj <= 1'b1;
    op(`FCS_OP_PROGRAM, a, 8'h00);
    chk(32'(v[`FCS_ST_ERR]), 32'h1);
    err_inj <= 1'b0;
    op(`FCS_OP_RESET, 17'h0, 8'hFF);
    chk(32'(v[`FCS_ST_ERR]), 32'h0);
    rchk(`FCS_OP_READ, a, pexp(a, 8'h00));
    busy_reads = 5;
    op(`FCS_OP_ERASE, 17'h0, 8'hFF);
    chk(v, 32'h10);
    em.delete();
    rchk(`FCS_OP_READ, a, 8'hFF);
    rchk(`FCS_OP_READ, 17'($urandom), 8'hFF);
    results();
  end
endmodule : tb_top
